// ==== hdl/dbsx_consts.vh ====
`ifndef DBSX_CONSTS_VH
`define DBSX_CONSTS_VH

// register indices; byte address is four times the index
`define DBSX_IDX_BW_CLAMP     8'h3B
`define DBSX_IDX_CAL_LOW      8'h3C
`define DBSX_IDX_CAL_HIGH     8'h3D
`define DBSX_IDX_FREQ_LOW     8'h07
`define DBSX_IDX_FREQ_HIGH    8'h0D
`define DBSX_ADDR_W           10
`define DBSX_IDX_LSB          2

// reset values
`define DBSX_RST_BW_CLAMP     8'h98
`define DBSX_RST_CAL_LOW      8'h99
`define DBSX_RST_CAL_HIGH     8'h99

// field positions in the bandwidth / clamp register
`define DBSX_BIT_AUTO_BW      7
`define DBSX_BIT_CLAMP        3

// bus answers
`define DBSX_RESP_OKAY        2'b00
`define DBSX_RESP_SLVERR      2'b10

`endif

// ==== hdl/dbsx_regs.v ====
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "dbsx_consts.vh"

// Overview of operation
// - auto bit picks acquisition/locked; else locked only
// - clamp bit freezes integrator at frequency limit
// - reported frequency frozen while integrator clamped
// - writable low and high bytes of calibration word
module dbsx_regs #(
    parameter FREQ_W = 16
) (
    input  wire                    ref_clk,
    input  wire                    rstn,
    input  wire [`DBSX_ADDR_W-1:0] s_axi_awaddr,
    input  wire                    s_axi_awvalid,
    output reg                     s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output reg                     s_axi_wready,
    output reg  [1:0]              s_axi_bresp,
    output reg                     s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [`DBSX_ADDR_W-1:0] s_axi_araddr,
    input  wire                    s_axi_arvalid,
    output reg                     s_axi_arready,
    output reg  [31:0]             s_axi_rdata,
    output reg  [1:0]              s_axi_rresp,
    output reg                     s_axi_rvalid,
    input  wire                    s_axi_rready,
    input  wire                    loopLocked,
    input  wire                    loopAtMinFreq,
    input  wire                    loopAtMaxFreq,
    input  wire [FREQ_W-1:0]       loopFrequency,
    output reg                     useAcquisitionBw,
    output reg                     integratorHold,
    output reg  [FREQ_W-1:0]       reportedLoopFrequency,
    output reg  [15:0]             nominalFreqWord
);

    // only the two live bits are stored; the rest of the register is wired zero
    reg        automaticLoopWidthChoice;
    reg        firstLoopIntegratorClamp;

    // reset image of the bandwidth / clamp register, so single bits can be picked
    localparam [7:0] RST_BW_CLAMP = `DBSX_RST_BW_CLAMP;
    reg [7:0]  calLow;
    reg [7:0]  calHigh;

    // captured write halves; address and data may arrive in either order
    reg                    awHeld;
    reg                    wHeld;
    reg [`DBSX_ADDR_W-1:0] awAddr;
    reg [7:0]              wByte;
    reg                    wLane0;

    wire [7:0] wrIdx  = awAddr[`DBSX_ADDR_W-1:`DBSX_IDX_LSB];
    wire [7:0] rdIdx  = s_axi_araddr[`DBSX_ADDR_W-1:`DBSX_IDX_LSB];
    wire       doWrite = awHeld && wHeld && !s_axi_bvalid;
    wire       awTake  = s_axi_awvalid && s_axi_awready;
    wire       wTake   = s_axi_wvalid && s_axi_wready;
    wire       arTake  = s_axi_arvalid && s_axi_arready;

    wire [15:0] freqWide = loopFrequency; // sized to the status pair
    wire        atLimit  = loopAtMinFreq || loopAtMaxFreq;

    // write-side decode of the mapped registers
    wire wrMapped = (wrIdx == `DBSX_IDX_BW_CLAMP) || (wrIdx == `DBSX_IDX_CAL_LOW) ||
                    (wrIdx == `DBSX_IDX_CAL_HIGH) || (wrIdx == `DBSX_IDX_FREQ_LOW) ||
                    (wrIdx == `DBSX_IDX_FREQ_HIGH);

    // read mux; the frequency pair is read-only status
    reg [7:0] rdByte;
    reg       rdMapped;
    always @* begin
        rdByte   = 8'h00;
        rdMapped = 1'b1;
        case (rdIdx)
            `DBSX_IDX_BW_CLAMP: begin
                rdByte[`DBSX_BIT_AUTO_BW] = automaticLoopWidthChoice;
                rdByte[`DBSX_BIT_CLAMP]   = firstLoopIntegratorClamp;
            end
            `DBSX_IDX_CAL_LOW:   rdByte = calLow;
            `DBSX_IDX_CAL_HIGH:  rdByte = calHigh;
            `DBSX_IDX_FREQ_LOW:  rdByte = reportedLoopFrequency[7:0];
            `DBSX_IDX_FREQ_HIGH: rdByte = reportedLoopFrequency[15:8];
            default:             rdMapped = 1'b0;
        endcase
    end

    // write channel handshake: one transfer in flight, ready drops once held
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DBSX_RESP_OKAY;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= {`DBSX_ADDR_W{1'b0}};
            wByte         <= 8'h00;
            wLane0        <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld && !awTake && !s_axi_bvalid;
            s_axi_wready  <= !wHeld && !wTake && !s_axi_bvalid;
            if (awTake) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld  <= 1'b1;
                wByte  <= s_axi_wdata[7:0];
                wLane0 <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMapped ? `DBSX_RESP_OKAY : `DBSX_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register storage; only byte lane 0 carries data, upper bits ignored
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            automaticLoopWidthChoice <= RST_BW_CLAMP[`DBSX_BIT_AUTO_BW];
            firstLoopIntegratorClamp <= RST_BW_CLAMP[`DBSX_BIT_CLAMP];
            calLow                   <= `DBSX_RST_CAL_LOW;
            calHigh                  <= `DBSX_RST_CAL_HIGH;
        end else if (doWrite && wLane0) begin
            case (wrIdx)
                `DBSX_IDX_BW_CLAMP: begin
                    automaticLoopWidthChoice <= wByte[`DBSX_BIT_AUTO_BW];
                    firstLoopIntegratorClamp <= wByte[`DBSX_BIT_CLAMP];
                end
                `DBSX_IDX_CAL_LOW:  calLow  <= wByte;
                `DBSX_IDX_CAL_HIGH: calHigh <= wByte;
                default: begin
                end
            endcase
        end
    end

    // read channel: address taken, data answered the next cycle
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DBSX_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !arTake;
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rdByte};
                s_axi_rresp  <= rdMapped ? `DBSX_RESP_OKAY : `DBSX_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // loop controls; registered so every output comes from a flop,
    // at the cost of one cycle of lag behind the loop's own flags
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            useAcquisitionBw      <= 1'b0;
            integratorHold        <= 1'b0;
            reportedLoopFrequency <= {FREQ_W{1'b0}};
            nominalFreqWord       <= {`DBSX_RST_CAL_HIGH, `DBSX_RST_CAL_LOW};
        end else begin
            useAcquisitionBw <= automaticLoopWidthChoice && !loopLocked;
            integratorHold   <= firstLoopIntegratorClamp && atLimit;
            if (!(firstLoopIntegratorClamp && atLimit))
                reportedLoopFrequency <= freqWide[FREQ_W-1:0];
            nominalFreqWord <= {calHigh, calLow};
        end
    end

endmodule
`default_nettype wire

// ==== test/dbsx_regs_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbsx_regs_sva #(
    parameter FREQ_W = 16
) (
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              loopLocked,
    input wire logic              loopAtMinFreq,
    input wire logic              loopAtMaxFreq,
    input wire logic [FREQ_W-1:0] loopFrequency,
    input wire logic              useAcquisitionBw,
    input wire logic              integratorHold,
    input wire logic [FREQ_W-1:0] reportedLoopFrequency
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // a read address is taken: arvalid and arready high in the same cycle
    sequence rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // loop outputs lag their causes by one cycle
    acq_cause_a: assert property (useAcquisitionBw |-> !$past(loopLocked)) else $error("acq bw while locked");
    hold_cause_a: assert property (integratorHold |-> $past(loopAtMinFreq || loopAtMaxFreq)) else $error("hold off limit");
    freq_frozen_a: assert property (integratorHold |-> $stable(reportedLoopFrequency)) else $error("freq moved");
    // skip the edge just after reset, output still holds its reset value
    freq_follow_a: assert property ($past(rstn) && !$past(loopAtMinFreq || loopAtMaxFreq)
        |-> reportedLoopFrequency == $past(loopFrequency)) else $error("freq lag");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("rdata high");
    read_answer_a: assert property (rdTake |-> ##[1:2] s_axi_rvalid) else $error("no rvalid");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready busy");
    rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule
bind dbsx_regs dbsx_regs_sva #(.FREQ_W(FREQ_W)) chk_u (.*);
`default_nettype wire

// ==== test/dbsx_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic        ref_clk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_bready = 1, s_axi_rready = 1, loopLocked = 0;
    logic        loopAtMinFreq = 0, loopAtMaxFreq = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        useAcquisitionBw, integratorHold;
    logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] loopFrequency = 16'hABCD, reportedLoopFrequency, nominalFreqWord;
    int          n_fail = 0, tests_run = 0, cyc = 0;
    dbsx_regs dut_u (.*);
    initial forever #2 ref_clk = ~ref_clk;
    // hang guard, far above the 75 or so cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            wrap_up;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("mismatches %0d of %0d checks", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // address and data offered together, each released when taken
    task wr(input [7:0] i, input [7:0] d, input [1:0] r);
        @(posedge ref_clk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(32'(s_axi_bresp), 32'(r));
    endtask
    task rd(input [7:0] i, input [7:0] d, input [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, {24'h00_0000, d});
        chk(32'(s_axi_rresp), 32'(r));
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(8'h3B, 8'h88, 2'b00);
        rd(8'h3D, 8'h99, 2'b00);
        chk(32'(nominalFreqWord), 32'h0000_9999);
        wr(8'h3B, 8'h77, 2'b00);
        rd(8'h3B, 8'h00, 2'b00);
        wr(8'h3C, 8'h12, 2'b00);
        wr(8'h3D, 8'h34, 2'b00);
        rd(8'h3C, 8'h12, 2'b00);
        chk(32'(nominalFreqWord), 32'h0000_3412);
        // lane 0 strobe off: answered OKAY, byte untouched
        s_axi_wstrb <= 4'h0;
        wr(8'h3C, 8'hAA, 2'b00);
        s_axi_wstrb <= 4'h1;
        rd(8'h3C, 8'h12, 2'b00);
        // status pair is read-only; write answered but ignored
        wr(8'h07, 8'h55, 2'b00);
        rd(8'h07, 8'hCD, 2'b00);
        wr(8'h00, 8'h55, 2'b10);
        rd(8'h00, 8'h00, 2'b10);
        // auto bandwidth and clamp both on, loop unlocked
        wr(8'h3B, 8'hFF, 2'b00);
        repeat (2) @(posedge ref_clk);
        chk(32'(useAcquisitionBw), 32'h0000_0001);
        loopLocked <= 1'b1;
        loopAtMaxFreq <= 1'b1;
        loopFrequency <= 16'h5678;
        repeat (3) @(posedge ref_clk);
        chk(32'(useAcquisitionBw), 32'h0000_0000);
        chk(32'(integratorHold), 32'h0000_0001);
        rd(8'h07, 8'hCD, 2'b00);
        rd(8'h0D, 8'hAB, 2'b00);
        loopAtMaxFreq <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(32'(reportedLoopFrequency), 32'h0000_5678);
        // both off: locked bandwidth only, no freeze at a limit
        wr(8'h3B, 8'h00, 2'b00);
        loopLocked <= 1'b0;
        loopAtMinFreq <= 1'b1;
        loopFrequency <= 16'h1111;
        repeat (3) @(posedge ref_clk);
        chk(32'(useAcquisitionBw), 32'h0000_0000);
        chk(32'(reportedLoopFrequency), 32'h0000_1111);
        chk(32'(integratorHold), 32'h0000_0000);
        wrap_up;
    end
endmodule
`default_nettype wire
